// ===== inc/tta_pkg.sv
// Package of constants and carriers for the trigger acknowledge block
package tta_pkg;
   // Source id width, shared by carriers
   localparam int TTA_ID_W = 4;
   // Lockout counter width
   localparam int TTA_CNT_W = 5;
   // Lockout lengths in CPU clock cycles
   localparam logic [4:0] TTA_LOCK_NORM = 5'h0A;  // Plain event, 8..12
   localparam logic [4:0] TTA_LOCK_SW = 5'h0C;    // Event during sw exec, 9..16
   localparam logic [4:0] TTA_LOCK_DSW = 5'h10;   // Sw exec at completion, 16
   // Register byte offsets
   localparam logic [7:0] TTA_OFS_TEN = 8'h00;    // trigger_enable_reg
   localparam logic [7:0] TTA_OFS_LOCK = 8'h04;   // Lockout / flag state
   localparam logic [7:0] TTA_OFS_IST = 8'h08;    // Interrupt status
   localparam logic [7:0] TTA_OFS_ICLR = 8'h0C;   // Interrupt clear, write only
   localparam logic [7:0] TTA_OFS_IEN = 8'h10;    // Interrupt enable
   localparam logic [7:0] TTA_OFS_CHN = 8'h14;    // Chain count in force
   // Reset values
   localparam logic [15:0] TTA_TEN_RST = 16'h0000;
   localparam logic [1:0] TTA_IEN_RST = 2'h0;
   // Interrupt status bit positions
   localparam int TTA_IST_CPUIRQ = 0;  // Transfer raised a CPU request
   localparam int TTA_IST_DROP = 1;    // Trigger ignored: locked, disabled or outranked
   // AXI responses
   localparam logic [1:0] TTA_RESP_OK = 2'h0;
   localparam logic [1:0] TTA_RESP_SLVERR = 2'h2;

   // Accepted trigger to the transfer datapath
   typedef struct packed {
      logic valid;
      logic [TTA_ID_W-1:0] id;
   } tta_trig_t;

   // Completion report from the datapath
   typedef struct packed {
      logic done;                 // Transfer finished, one-cycle pulse
      logic cnt_zero;             // Count reached zero, CPU request due
      logic [TTA_ID_W-1:0] id;    // Source that activated it
   } tta_done_t;

   // Control record fetch report
   typedef struct packed {
      logic load;                 // Record read, one-cycle pulse
      logic first;                // First record of the chain
      logic [7:0] count;          // transfer_count field
   } tta_rec_t;
endpackage

// ===== rtl/tta_trigger_ack.sv
// Trigger acknowledge, lockout and source flag clearing of the transfer_controller
//
// How it works
// RULE1: plain trigger locks source 8..12 cycles
// RULE2: trigger during sw instruction locks 9..16
// RULE3: accepted while busy: lock after completion
// RULE4: sw instruction at completion: lock 16
// RULE5: flash flag set blocks new flash requests
// RULE6: flash request accepted after flag cleared
// RULE7: flash flag cleared 8..12 (9..16 sw)
// RULE8: flash accepted while busy clears after completion
// RULE9: capture flag set blocks capture events
// RULE10: capture flag clears after cycles plus tick
// RULE11: capture accepted while busy: same after completion
// RULE12: flash source never raises CPU interrupt
// RULE13: first record count governs whole chain
// RULE14: software keeps triggers quiet before low power
// RULE15: enable bits changed only when source idle
// RULE16: records never touch trigger enable register
// RULE17: records never clear peripheral status flags
// RULE18: CPU request clears that source enable bit
// RULE19: independent lockout counter per source
module tta_trigger_ack
   import tta_pkg::*;
#(
   parameter int N_ORD = 8  // Ordinary peripheral sources
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [N_ORD-1:0] ord_evt,
   input wire logic flash_evt,
   input wire logic cap_evt,
   input wire logic sw_exec,
   input wire logic xfer_busy,
   input wire logic tmr_tick,
   input wire tta_done_t done_in,
   input wire tta_rec_t rec_in,
   output tta_trig_t trig_q,
   output logic cpu_irq_q,
   output logic [TTA_ID_W-1:0] cpu_irq_id_q,
   output logic flash_ready_req_flag_q,
   output logic cap_flag_q,
   output logic [7:0] chain_count_q,
   output logic irq_q,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int NS = N_ORD + 2;     // All sources
   localparam int FL = N_ORD;         // Flash-ready source index
   localparam int CP = N_ORD + 1;     // Capture timer source index
   // Refuse widths the id and registers cannot carry
   if (N_ORD < 1 || NS > 16) begin : g_chk
      $error("N_ORD must be 1..14");
   end
   ////////////////////////////////////////////////////////////////////////
   // Event synchronisers and edge detection
   logic [NS-1:0] raw;        // Peripheral requests, other domain
   logic [NS-1:0] s1_q;       // First stage, read only by s2
   logic [NS-1:0] s2_q;       // Second stage
   logic [NS-1:0] s3_q;       // Previous level for edges
   logic [NS-1:0] rise;       // Fresh request pulses
   assign raw = {cap_evt, flash_evt, ord_evt};
   assign rise = s2_q & ~s3_q;
   // Two flops before any logic, then edge memory
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Register file state
   logic [NS-1:0] ten_q, ten_d;    // trigger_enable_reg
   logic [1:0] ist_q, ist_d;       // Sticky interrupt status
   logic [1:0] ien_q, ien_d;       // Interrupt enable
   logic wr_go;                    // Write address and data both held
   logic [7:0] aw_q, aw_d;
   logic [31:0] wd_q, wd_d;
   logic [3:0] ws_q, ws_d;
   logic awh_q, awh_d, wh_q, wh_d; // Halves of a write captured
   ////////////////////////////////////////////////////////////////////////
   // Per-source lockout and acknowledge
   logic [NS-1:0] pend_q, pend_d;        // Accepted while busy
   logic [TTA_CNT_W-1:0] cnt_q [NS];     // Lockout counters
   logic [TTA_CNT_W-1:0] cnt_d [NS];
   logic twait_q, twait_d;               // Capture waits for timer tick
   logic [NS-1:0] lock;                  // Source refuses triggers
   logic [NS-1:0] cand;                  // Requests that could be taken
   logic [NS-1:0] take;                  // Request taken this cycle
   tta_trig_t trig_d;
   logic drop;                           // Some request ignored
   // Lowest set bit wins, so one trigger reaches the datapath per cycle
   function automatic logic [NS-1:0] first_one(input logic [NS-1:0] v);
      return v & (~v + NS'(1));
   endfunction
   // Lockout length for a new start
   function automatic logic [TTA_CNT_W-1:0] lock_len(input logic sw,
                                                     input logic at_done);
      if (!sw) return TTA_LOCK_NORM; // RULE1
      return at_done ? TTA_LOCK_DSW : TTA_LOCK_SW; // RULE2 RULE4
   endfunction
   // Lock covers pending wait, running count and capture tick wait
   always_comb begin
      for (int i = 0; i < NS; i++) begin
         lock[i] = pend_q[i] || (cnt_q[i] != '0); // RULE5 RULE9
      end
      lock[CP] = lock[CP] || twait_q; // RULE10
   end
   assign cand = rise & ten_q & ~lock; // RULE6 RULE19
   assign take = first_one(cand);
   // A blocked or outranked request is lost and reported
   assign drop = |(rise & ~take);
   // Next state of every lockout
   always_comb begin
      pend_d = pend_q;
      twait_d = twait_q;
      trig_d = '0;
      for (int i = 0; i < NS; i++) begin
         cnt_d[i] = cnt_q[i];
         if (take[i]) begin
            trig_d.valid = 1'b1;
            trig_d.id = TTA_ID_W'(i);
            if (xfer_busy) begin
               // Lockout count starts only once the running transfer ends
               pend_d[i] = 1'b1; // RULE3 RULE8 RULE11
            end else begin
               cnt_d[i] = lock_len(sw_exec, 1'b0); // RULE1 RULE2 RULE7
            end
         end else if (pend_q[i] && done_in.done) begin
            pend_d[i] = 1'b0;
            cnt_d[i] = lock_len(sw_exec, 1'b1); // RULE3 RULE4 RULE8
         end else if (cnt_q[i] != '0) begin
            cnt_d[i] = cnt_q[i] - 1'b1;
            // Capture flag also needs a timer clock edge
            if (i == CP && cnt_q[i] == TTA_CNT_W'(1)) begin
               twait_d = 1'b1; // RULE10 RULE11
            end
         end
      end
      if (twait_q && tmr_tick) begin
         twait_d = 1'b0; // RULE10
      end
   end
   // Lockout registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pend_q <= '0;
         twait_q <= 1'b0;
         trig_q <= '0;
         flash_ready_req_flag_q <= 1'b0;
         cap_flag_q <= 1'b0;
         for (int i = 0; i < NS; i++) begin
            cnt_q[i] <= '0;
         end
      end else begin
         pend_q <= pend_d;
         twait_q <= twait_d;
         trig_q <= trig_d;
         flash_ready_req_flag_q <= pend_d[FL] || (cnt_d[FL] != '0); // RULE7
         cap_flag_q <= pend_d[CP] || (cnt_d[CP] != '0) || twait_d; // RULE10
         for (int i = 0; i < NS; i++) begin
            cnt_q[i] <= cnt_d[i];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Completion: CPU request and chain count
   logic cpu_irq_d;
   logic [TTA_ID_W-1:0] cpu_irq_id_d;
   logic [7:0] chain_d;
   logic irq_src;  // Completion that asks for the CPU
   // Flash-ready never interrupts the CPU
   assign irq_src = done_in.done && done_in.cnt_zero &&
                    (done_in.id != TTA_ID_W'(FL)); // RULE12
   // Completion pulse and chain count next values
   always_comb begin
      cpu_irq_d = irq_src;
      cpu_irq_id_d = irq_src ? done_in.id : cpu_irq_id_q;
      chain_d = chain_count_q;
      // Later records keep the first count in force
      if (rec_in.load && rec_in.first) begin
         chain_d = rec_in.count; // RULE13
      end
   end
   // Completion registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cpu_irq_q <= 1'b0;
         cpu_irq_id_q <= '0;
         chain_count_q <= '0;
      end else begin
         cpu_irq_q <= cpu_irq_d;
         cpu_irq_id_q <= cpu_irq_id_d;
         chain_count_q <= chain_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   logic [31:0] rdata_d;
   logic [1:0] rresp_d, bresp_d;
   logic rd_ok, wr_ok;
   assign wr_go = awh_q && wh_q && !s_axi_bvalid;
   assign wr_ok = (aw_q[1:0] == 2'h0) && (aw_q[7:2] <= TTA_OFS_CHN[7:2]);
   assign rd_ok = (s_axi_araddr[1:0] == 2'h0) &&
                  (s_axi_araddr[7:2] <= TTA_OFS_CHN[7:2]);
   // Read mux
   always_comb begin
      rdata_d = '0;
      unique case (s_axi_araddr)
         TTA_OFS_TEN: rdata_d[NS-1:0] = ten_q;
         TTA_OFS_LOCK: rdata_d[NS-1:0] = lock;
         TTA_OFS_IST: rdata_d[1:0] = ist_q;
         TTA_OFS_IEN: rdata_d[1:0] = ien_q;
         TTA_OFS_CHN: rdata_d[7:0] = chain_count_q;
         default: rdata_d = '0;  // Clear register and holes read zero
      endcase
      rresp_d = rd_ok ? TTA_RESP_OK : TTA_RESP_SLVERR;
      bresp_d = wr_ok ? TTA_RESP_OK : TTA_RESP_SLVERR;
   end
   // Register and handshake next values
   always_comb begin
      awh_d = awh_q;
      wh_d = wh_q;
      aw_d = aw_q;
      wd_d = wd_q;
      ws_d = ws_q;
      ten_d = ten_q;
      ien_d = ien_q;
      ist_d = ist_q;
      // Capture each half as it arrives, in either order
      if (s_axi_awvalid && s_axi_awready) begin
         awh_d = 1'b1;
         aw_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wh_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (wr_go) begin
         awh_d = 1'b0;
         wh_d = 1'b0;
         if (aw_q == TTA_OFS_TEN) begin
            for (int b = 0; b < NS; b++) begin
               if (ws_q[b/8]) begin
                  ten_d[b] = wd_q[b];
               end
            end
         end
         if (aw_q == TTA_OFS_IEN && ws_q[0]) begin
            ien_d = wd_q[1:0];
         end
         if (aw_q == TTA_OFS_ICLR && ws_q[0]) begin
            ist_d = ist_q & ~wd_q[1:0];
         end
      end
      // Hardware disable beats a racing software write, and events are
      // set after the clear so a same-cycle event is kept
      if (irq_src) begin
         ten_d[done_in.id] = 1'b0; // RULE18
         ist_d[TTA_IST_CPUIRQ] = 1'b1;
      end
      if (drop) begin
         ist_d[TTA_IST_DROP] = 1'b1;
      end
   end
   // Bus and register flops
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         awh_q <= 1'b0;
         wh_q <= 1'b0;
         aw_q <= '0;
         wd_q <= '0;
         ws_q <= '0;
         ten_q <= TTA_TEN_RST[NS-1:0];
         ien_q <= TTA_IEN_RST;
         ist_q <= '0;
         irq_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= TTA_RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= TTA_RESP_OK;
      end else begin
         awh_q <= awh_d;
         wh_q <= wh_d;
         aw_q <= aw_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         ten_q <= ten_d;
         ien_q <= ien_d;
         ist_q <= ist_d;
         irq_q <= |(ist_d & ien_d);
         // Ready only while that half is still free
         s_axi_awready <= !awh_d && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !wh_d && !(s_axi_wvalid && s_axi_wready);
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= bresp_d;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // One read in flight; arready pulses for one cycle
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // tta_trigger_ack

// ===== sim/tb.sv
// Self-checking bench for the trigger acknowledge block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tta_pkg::*;
   localparam int N = 8;  // Ordinary sources
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [N+1:0] evt = '0;  // Ordinary, flash, capture lines
   logic sw_exec = 1'b0;
   logic tmr_tick = 1'b0;
   logic czero = 1'b0;  // Partner reports count reaching zero
   logic [7:0] rec_cnt = 8'h00;
   logic [4:0] xlen = 5'h06;
   logic xfer_busy, cpu_irq_q, flash_ready_req_flag_q, cap_flag_q, irq_q;
   tta_done_t done_in;
   tta_rec_t rec_in;
   tta_trig_t trig_q;
   logic [TTA_ID_W-1:0] cpu_irq_id_q;
   logic [7:0] chain_count_q, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int miscompares = 0;
   int cmp_count = 0;
   always #20 clk_sys = ~clk_sys;
   // Random instruction and timer activity on every cycle
   always @(posedge clk_sys) begin
      sw_exec <= 1'($urandom_range(0, 1));
      tmr_tick <= ($urandom_range(0, 3) == 0);
   end
   tta_trigger_ack #(.N_ORD(N)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
      .ord_evt(evt[N-1:0]), .flash_evt(evt[N]), .cap_evt(evt[N+1]),
      .sw_exec(sw_exec), .xfer_busy(xfer_busy), .tmr_tick(tmr_tick),
      .done_in(done_in), .rec_in(rec_in), .trig_q(trig_q),
      .cpu_irq_q(cpu_irq_q), .cpu_irq_id_q(cpu_irq_id_q),
      .flash_ready_req_flag_q(flash_ready_req_flag_q), .cap_flag_q(cap_flag_q),
      .chain_count_q(chain_count_q), .irq_q(irq_q),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   tta_far_model u_far (.clk_sys(clk_sys), .rst_n(rst_n), .trig(trig_q),
      .czero(czero), .rec_cnt(rec_cnt), .len(xlen), .busy(xfer_busy),
      .done(done_in), .rec(rec_in));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] en_after(logic [31:0] en, int id);
      return en & ~(32'h1 << id);
   endfunction
   function automatic logic [7:0] exp_chain(logic [7:0] first, later);
      return first;
   endfunction
   task automatic chk32(input logic [31:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t %s", $time, what);
      end
   endtask
   task automatic close_out();
      $display("compared %0d, mismatched %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Bus tasks start just after an edge and hold until taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);  // Release never shares a step with a new request
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = {s_axi_rresp, s_axi_rdata[29:0]};
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);  // Release never shares a step with a new request
   endtask
   // Request pulse of two cycles, one edge apart from the last
   // No low-power entry is modelled, so no trigger ever precedes one
   task automatic fire(input int ix);
      @(posedge clk_sys);
      evt[ix] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      evt[ix] <= 1'b0;
   endtask
   task automatic wait_trig(input int lim, output logic [31:0] id);
      id = 32'hFFFF_FFFF;
      for (int k = 0; k < lim && id[31]; k++) begin
         @(posedge clk_sys);
         if (trig_q.valid === 1'b1) id = 32'(trig_q.id);
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      int i;
      void'($urandom(90));
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      axi_rd(TTA_OFS_TEN, d);
      chk32(d, {16'h0, TTA_TEN_RST}, "enable reset value");
      axi_rd(TTA_OFS_IEN, d);
      chk32(d, {30'h0, TTA_IEN_RST}, "irq enable reset value");
      axi_rd(8'h18, d);
      chk32(d[31:30], TTA_RESP_SLVERR, "unmapped read");
      axi_wr(TTA_OFS_TEN, 32'h0000_03FF);
      $display("test regs done");
      // Own re-request dropped, neighbour taken while own lock runs
      for (int k = 0; k < 4; k++) begin
         i = $urandom_range(0, N - 1);
         xlen <= 5'($urandom_range(4, 12));
         fire(i);
         wait_trig(12, d);
         chk32(d, i, "ordinary accept");
         fire(i);
         fire((i + 1) % N);
         wait_trig(12, d);
         chk32(d, (i + 1) % N, "neighbour in lockout");
         repeat (40) @(posedge clk_sys);
      end
      axi_rd(TTA_OFS_IST, d);
      chk32(d[1], 1'b1, "drop status");
      axi_wr(TTA_OFS_ICLR, 32'h3);
      $display("test lockout done");
      // Completion with count zero: request, enable clear, irq masking
      czero <= 1'b1;
      rec_cnt <= 8'($urandom_range(1, 200));
      axi_wr(TTA_OFS_IEN, 32'h1);
      i = $urandom_range(0, N - 1);
      fire(i);
      for (int k = 0; k < 40 && cpu_irq_q !== 1'b1; k++) @(posedge clk_sys);
      chk32(cpu_irq_id_q, i, "cpu request source");
      chk32(chain_count_q, exp_chain(rec_cnt, rec_cnt + 8'h05), "chain");
      repeat (2) @(posedge clk_sys);
      chk32(irq_q, 1'b1, "irq raised");
      axi_rd(TTA_OFS_TEN, d);
      chk32(d, en_after(32'h3FF, i), "enable bit cleared");
      axi_wr(TTA_OFS_IEN, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk32(irq_q, 1'b0, "irq masked");
      axi_wr(TTA_OFS_IEN, 32'h1);
      axi_wr(TTA_OFS_ICLR, 32'h3);
      repeat (2) @(posedge clk_sys);
      chk32(irq_q, 1'b0, "irq cleared");
      axi_wr(TTA_OFS_TEN, 32'h0000_03FF);
      $display("test cpu request done");
      // Flash then capture: flag blocks repeats until it clears
      for (int s = N; s <= N + 1; s++) begin
         czero <= (s == N);
         fire(s);
         wait_trig(12, d);
         chk32(d, s, "flag source accept");
         chk32(flash_ready_req_flag_q | cap_flag_q, 1'b1, "flag set");
         fire(s);
         wait_trig(8, d);
         chk32(d, 32'hFFFF_FFFF, "blocked while flag set");
         for (int k = 0; k < 80 && (flash_ready_req_flag_q | cap_flag_q); k++)
            @(posedge clk_sys);
         chk32(flash_ready_req_flag_q | cap_flag_q, 1'b0, "flag off");
         fire(s);
         wait_trig(12, d);
         chk32(d, s, "accept after clear");
         repeat (40) @(posedge clk_sys);
      end
      $display("test flags done");
      close_out();
   end
endmodule // tb

// ===== sim/tta_far_model.sv
// Far-side model: transfer datapath answering accepted triggers
module tta_far_model
   import tta_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire tta_trig_t trig,
   input wire logic czero,
   input wire logic [7:0] rec_cnt,
   input wire logic [4:0] len,
   output logic busy,
   output tta_done_t done,
   output tta_rec_t rec
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_q = 1'b0;
   tta_done_t done_q = '0;
   tta_rec_t rec_q = '0;
   logic [4:0] cnt_q = 5'h00;  // Cycles left, len of 4 or more
   logic pend_q = 1'b0;  // One waiting trigger, one transfer at a time
   logic [TTA_ID_W-1:0] pid_q = '0;
   logic [TTA_ID_W-1:0] cid_q = '0;
   assign busy = busy_q;
   assign done = done_q;
   assign rec = rec_q;
   ////////////////////////////////////////////////////////////////////////////
   // Records only carry counts, never enable or status targets
   always @(posedge clk_sys) begin
      done_q <= '0;
      rec_q <= '0;
      if (!rst_n) begin
         busy_q <= 1'b0;
         pend_q <= 1'b0;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 5'h01;
         if (cnt_q == len - 5'h01) rec_q <= {1'b1, 1'b1, rec_cnt};
         if (cnt_q == len - 5'h03) rec_q <= {1'b1, 1'b0, rec_cnt + 8'h05};
         if (cnt_q == 5'h01) begin
            busy_q <= 1'b0;
            done_q <= {1'b1, czero, cid_q};
         end
      end else if (pend_q) begin
         busy_q <= 1'b1;
         cnt_q <= len;
         cid_q <= pid_q;
         pend_q <= 1'b0;
      end
      // Late trigger wins over the start, so none is lost
      if (rst_n && trig.valid) begin
         pend_q <= 1'b1;
         pid_q <= trig.id;
      end
   end
endmodule // tta_far_model

// ===== sim/tta_props.sv
// Concurrent checks on the trigger acknowledge block ports
module tta_props
   import tta_pkg::*;
#(
   parameter int N_ORD = 8  // Ordinary sources, flash is index N_ORD
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic xfer_busy,
   input wire tta_done_t done_in,
   input wire tta_rec_t rec_in,
   input wire tta_trig_t trig_q,
   input wire logic cpu_irq_q,
   input wire logic [TTA_ID_W-1:0] cpu_irq_id_q,
   input wire logic flash_ready_req_flag_q,
   input wire logic cap_flag_q,
   input wire logic [7:0] chain_count_q,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   timeunit 1ns;
   timeprecision 1ps;
   // One domain, so one clock and one disable for all
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   a_flash_no_irq: assert property (done_in.done && done_in.cnt_zero &&
      done_in.id == TTA_ID_W'(N_ORD) |=> !cpu_irq_q)
      else $error("flash completion raised a cpu request");
   a_cpu_irq_src: assert property (done_in.done && done_in.cnt_zero &&
      done_in.id != TTA_ID_W'(N_ORD) |=> cpu_irq_q &&
      cpu_irq_id_q == $past(done_in.id))
      else $error("cpu request missing or wrong source");
   a_chain_first: assert property (rec_in.load && rec_in.first
      |=> chain_count_q == $past(rec_in.count))
      else $error("first record count not taken");
   a_chain_later: assert property (rec_in.load && !rec_in.first
      |=> $stable(chain_count_q))
      else $error("later record count disturbed chain count");
   // Lock from an idle start must last 8 and end by 16 cycles
   a_flash_len: assert property ($rose(flash_ready_req_flag_q) &&
      !xfer_busy && !$past(xfer_busy) |-> flash_ready_req_flag_q[*8]
      ##[1:9] !flash_ready_req_flag_q)
      else $error("flash flag length out of range");
   a_cap_len: assert property ($rose(cap_flag_q) |-> cap_flag_q[*8])
      else $error("capture flag cleared too early");
   a_flash_block: assert property (trig_q.valid &&
      trig_q.id == TTA_ID_W'(N_ORD) |-> !$past(flash_ready_req_flag_q))
      else $error("flash trigger taken while flag set");
   a_cap_block: assert property (trig_q.valid &&
      trig_q.id == TTA_ID_W'(N_ORD + 1) |-> !$past(cap_flag_q))
      else $error("capture trigger taken while flag set");
   a_b_follows: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response late");
   a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before taken");
endmodule // tta_props

bind tta_trigger_ack tta_props #(.N_ORD(N_ORD)) u_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .xfer_busy(xfer_busy),
   .done_in(done_in), .rec_in(rec_in), .trig_q(trig_q),
   .cpu_irq_q(cpu_irq_q), .cpu_irq_id_q(cpu_irq_id_q),
   .flash_ready_req_flag_q(flash_ready_req_flag_q), .cap_flag_q(cap_flag_q),
   .chain_count_q(chain_count_q), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready));
